//--- hw/ppm_pkg.sv
package ppm_pkg;
    // register addresses in the upper register set, bank 1
    localparam logic [7:0] PORT1_PULLUP_ENABLE_ADDR = 8'hE7;
    localparam logic [7:0] PORT2_UPPER_PIN_MODE_ADDR = 8'hE8;
    // reset values
    localparam logic [7:0] PORT1_PULLUP_ENABLE_RESET = 8'h00;
    localparam logic [7:0] PORT2_UPPER_PIN_MODE_RESET = 8'h00;
    // implemented bits of the pull-up register
    localparam logic [7:0] PORT1_PULLUP_ENABLE_MASK = 8'h7F;
    localparam int PORT1_PIN_COUNT = 7;
    localparam int PORT2_UPPER_PIN_COUNT = 4;
    // first port 2 pin handled by the high control byte
    localparam int PORT2_UPPER_FIRST_PIN = 4;
    // pin mode field encodings
    localparam logic [1:0] MODE_INPUT = 2'h0;
    localparam logic [1:0] MODE_INPUT_PULLUP = 2'h1;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
    localparam logic [1:0] MODE_ALTERNATE = 2'h3;
    typedef enum logic [1:0] {
        PPM_IN,
        PPM_IN_PU,
        PPM_OUT_PP,
        PPM_ALT
    } ppm_mode_e;
endpackage

//--- hw/ppm_pin_mode_decode.sv
`timescale 1ns/10ps
module ppm_pin_mode_decode (
    input wire logic [1:0] mode,
    output logic pullup_on,
    output logic drive_out,
    output logic analog_sel
);
    // ----------------------------------------
    // port 2 upper pin mode decode
    // ----------------------------------------
    always_comb begin
        pullup_on = (mode == ppm_pkg::MODE_INPUT_PULLUP);
        drive_out = (mode == ppm_pkg::MODE_PUSH_PULL);
        analog_sel = (mode == ppm_pkg::MODE_ALTERNATE);
    end
endmodule

//--- hw/ppm_port_config.sv
`timescale 1ns/10ps
module ppm_port_config (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic [13:0] port1_mode,
    output logic [6:0] port1_pullup_on,
    output logic [3:0] port2_upper_pullup_on,
    output logic [3:0] port2_upper_drive_out,
    output logic [3:0] port2_upper_digital_off,
    output logic analog_channel_4,
    output logic analog_channel_5,
    output logic analog_channel_6,
    output logic analog_channel_7,
    output logic level_detector_reference
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic forces_pullup_off(input logic [1:0] m);
        forces_pullup_off = (m == ppm_pkg::MODE_PUSH_PULL)
            || (m == ppm_pkg::MODE_ALTERNATE);
    endfunction

    // only bits 0-6 exist in the pull-up register
    function automatic logic [7:0] masked_pullup(input logic [7:0] v);
        masked_pullup = v & ppm_pkg::PORT1_PULLUP_ENABLE_MASK;
    endfunction

    // one pin's mode field out of a packed field vector
    function automatic logic [1:0] pin_field(
        input logic [13:0] fields,
        input int pin
    );
        pin_field = fields[2*pin +: 2];
    endfunction

    // ----------------------------------------
    // register file
    // ----------------------------------------
    // reg_addr is the direct register address; indirect forms
    // are resolved by the core before they reach here
    logic [7:0] pullup_q;
    logic [7:0] pullup_d;
    logic [7:0] p2mode_q;
    logic [7:0] p2mode_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic sel_pu;
    logic sel_p2;
    logic wr_pu;
    logic wr_p2;
    logic rd_pu;
    logic rd_p2;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    always_comb begin
        sel_pu = (reg_addr == ppm_pkg::PORT1_PULLUP_ENABLE_ADDR);
        sel_p2 = (reg_addr == ppm_pkg::PORT2_UPPER_PIN_MODE_ADDR);
        wr_pu = reg_wr && sel_pu;
        wr_p2 = reg_wr && sel_p2;
        rd_pu = reg_rd && sel_pu;
        rd_p2 = reg_rd && sel_p2;
    end

    assign reg_hit = sel_pu || sel_p2;

    // ----------------------------------------
    // port 1 pull-up enable register
    // ----------------------------------------
    always_comb begin
        pullup_d = pullup_q;
        if (wr_pu) begin
            pullup_d = masked_pullup(reg_wdata);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pullup_q <= ppm_pkg::PORT1_PULLUP_ENABLE_RESET;
        end else begin
            pullup_q <= pullup_d;
        end
    end

    // ----------------------------------------
    // port 2 upper pin mode register
    // ----------------------------------------
    always_comb begin
        p2mode_d = p2mode_q;
        if (wr_p2) begin
            p2mode_d = reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            p2mode_q <= ppm_pkg::PORT2_UPPER_PIN_MODE_RESET;
        end else begin
            p2mode_q <= p2mode_d;
        end
    end

    // ----------------------------------------
    // read data, held until the next read
    // ----------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (rd_pu) begin
            rdata_d = masked_pullup(pullup_q);
        end else if (rd_p2) begin
            rdata_d = p2mode_q;
        end else if (reg_rd) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // port 1 pull-up control
    // ----------------------------------------
    // a pin that drives or serves an alternate function
    // must not load its line with the pull-up
    logic [6:0] p1_forced_off;
    logic [6:0] p1_enabled;

    always_comb begin
        p1_forced_off = 7'h00;
        p1_enabled = pullup_q[6:0];
        for (int i = 0; i < ppm_pkg::PORT1_PIN_COUNT; i++) begin
            p1_forced_off[i] =
                forces_pullup_off(pin_field(port1_mode, i));
        end
    end

    always_comb begin
        port1_pullup_on = p1_enabled & ~p1_forced_off;
    end

    // ----------------------------------------
    // port 2 upper pin modes
    // ----------------------------------------
    logic [3:0] alt_sel;
    logic [13:0] p2_fields;
    logic [1:0] pin4_mode;
    logic [1:0] pin5_mode;
    logic [1:0] pin6_mode;
    logic [1:0] pin7_mode;

    // bits 1-0 belong to pin 4, bits 7-6 to pin 7
    always_comb begin
        p2_fields = {6'h00, p2mode_q};
        pin4_mode = pin_field(p2_fields, 0);
        pin5_mode = pin_field(p2_fields, 1);
        pin6_mode = pin_field(p2_fields, 2);
        pin7_mode = pin_field(p2_fields, 3);
    end

    // one decoder per pin keeps the pin numbers visible
    ppm_pin_mode_decode u_dec_pin4 (
        .mode(pin4_mode),
        .pullup_on(port2_upper_pullup_on[0]),
        .drive_out(port2_upper_drive_out[0]),
        .analog_sel(alt_sel[0])
    );

    ppm_pin_mode_decode u_dec_pin5 (
        .mode(pin5_mode),
        .pullup_on(port2_upper_pullup_on[1]),
        .drive_out(port2_upper_drive_out[1]),
        .analog_sel(alt_sel[1])
    );

    ppm_pin_mode_decode u_dec_pin6 (
        .mode(pin6_mode),
        .pullup_on(port2_upper_pullup_on[2]),
        .drive_out(port2_upper_drive_out[2]),
        .analog_sel(alt_sel[2])
    );

    ppm_pin_mode_decode u_dec_pin7 (
        .mode(pin7_mode),
        .pullup_on(port2_upper_pullup_on[3]),
        .drive_out(port2_upper_drive_out[3]),
        .analog_sel(alt_sel[3])
    );

    // ----------------------------------------
    // analog and reference routing
    // ----------------------------------------
    // a pin in alternate mode hands its pad to the converter,
    // so its digital input buffer is switched off
    always_comb begin
        port2_upper_digital_off = alt_sel;
        analog_channel_4 = alt_sel[0];
        analog_channel_5 = alt_sel[1];
        analog_channel_6 = alt_sel[2];
        analog_channel_7 = alt_sel[3];
        level_detector_reference = alt_sel[3];
    end
endmodule

//--- sim/ppm_assertions.sv
`timescale 1ns/10ps
module ppm_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic [13:0] port1_mode,
    input wire logic [6:0] port1_pullup_on,
    input wire logic [3:0] port2_upper_drive_out,
    input wire logic [3:0] port2_upper_digital_off,
    input wire logic analog_channel_7,
    input wire logic level_detector_reference
);
    logic [6:0] forced;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            forced[i] = port1_mode[2*i+1];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_pullup_forced_off: assert property (
        (port1_pullup_on & forced) == 7'h00) else $error("pull-up on");
    a_bit7_zero: assert property (
        reg_rd && reg_addr == 8'hE7 |=> !reg_rdata[7]) else $error("bit7");
    a_mode_exclusive: assert property (
        (port2_upper_drive_out & port2_upper_digital_off) == 4'h0)
        else $error("drive and analog");
    a_pin7_analog: assert property (
        analog_channel_7 == port2_upper_digital_off[3]) else $error("ch7");
    a_ref_follows: assert property (
        level_detector_reference == analog_channel_7) else $error("ref");
endmodule
bind ppm_port_config ppm_checker u_ppm_checker (.clk_sys, .reset,
    .reg_rd, .reg_addr, .reg_rdata, .port1_mode, .port1_pullup_on,
    .port2_upper_drive_out, .port2_upper_digital_off, .analog_channel_7,
    .level_detector_reference);

//--- sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, hit, a4, a5, a6, a7;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [13:0] port1_mode = 14'h0000;
    logic [6:0] p1;
    logic [3:0] pu, dr, off;
    logic lref;
    int err_total = 0, comparisons = 0;
    always #25 clk_sys = ~clk_sys;
    ppm_port_config u_ppm_port_config (.clk_sys, .reset, .reg_addr,
        .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_hit(hit),
        .port1_mode, .port1_pullup_on(p1), .port2_upper_pullup_on(pu),
        .port2_upper_drive_out(dr), .port2_upper_digital_off(off),
        .analog_channel_4(a4), .analog_channel_5(a5), .analog_channel_6(a6),
        .analog_channel_7(a7), .level_detector_reference(lref));
    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk_sys);
        reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk_sys);
        reg_rd = 0;
        chk("rdata", reg_rdata, exp);
    endtask
    task automatic pullup_test;
        port1_mode = 14'h3939;
        wr(8'hE7, 8'hFF);
        chk("hit_pu", {7'h00, hit}, 8'h01);
        rd(8'hE7, 8'h7F);
        chk("p1_mixed", {1'b0, p1}, 8'h19);
        port1_mode = 14'h0000;
        #1 chk("p1_all", {1'b0, p1}, 8'h7F);
    endtask
    task automatic reset_test;
        wr(8'hE8, 8'hFF);
        @(negedge clk_sys);
        reset = 1;
        repeat (2) @(negedge clk_sys);
        reset = 0;
        chk("rst_p2", {off, dr}, 8'h00);
        chk("rst_p1", {1'b0, p1}, 8'h00);
        rd(8'hE8, 8'h00);
    endtask
    task automatic p2_test;
        for (int m = 0; m < 4; m++) begin
            wr(8'hE8, {4{m[1:0]}});
            rd(8'hE8, {4{m[1:0]}});
            chk("p2_pd", {pu, dr},
                m == 1 ? 8'hF0 : m == 2 ? 8'h0F : 8'h00);
            chk("p2_an", {3'h0, lref, a7, a6, a5, a4},
                m == 3 ? 8'h1F : 8'h00);
        end
        wr(8'hE8, 8'hE4);
        chk("p2_map", {pu, dr}, 8'h24);
        chk("p2_alt", {off, a7, a6, a5, a4}, 8'h88);
        rd(8'hE9, 8'h00);
        chk("hit_none", {7'h00, hit}, 8'h00);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        reset = 0;
        rd(8'hE7, 8'h00);
        rd(8'hE8, 8'h00);
        pullup_test;
        p2_test;
        reset_test;
        give_verdict;
    end
    initial begin
        #50000;
        err_total++;
        give_verdict;
    end
endmodule
